// [fswc_defines.vh]
`ifndef FSWC_DEFINES_VH
`define FSWC_DEFINES_VH

// Register byte offsets within the slave window (low address byte)
`define FSWC_OFS_DATA_LO 8'h00
`define FSWC_OFS_DATA_HI 8'h04
`define FSWC_OFS_ADDR_LO 8'h08
`define FSWC_OFS_ADDR_HI 8'h0c
`define FSWC_OFS_CTRL 8'h10
`define FSWC_OFS_KEY 8'h14

// Register select codes
`define FSWC_IDX_DATA_LO 3'h0
`define FSWC_IDX_DATA_HI 3'h1
`define FSWC_IDX_ADDR_LO 3'h2
`define FSWC_IDX_ADDR_HI 3'h3
`define FSWC_IDX_CTRL 3'h4
`define FSWC_IDX_KEY 3'h5
`define FSWC_IDX_NONE 3'h7

// Control register bit positions
`define FSWC_CTRL_RD 0
`define FSWC_CTRL_WR 1
`define FSWC_CTRL_PROGRAM_ERASE_ENABLE 2
`define FSWC_CTRL_SEQUENCE_ERROR_FLAG 3
`define FSWC_CTRL_FREE 4
`define FSWC_CTRL_LATCH_ONLY_LOAD 5
`define FSWC_CTRL_CONFIG_SPACE_SELECT 6

// Reset values
`define FSWC_ADDR_LO_RST 8'h00
`define FSWC_ADDR_HI_RST 7'h00

// Unlock keys
`define FSWC_KEY_FIRST 8'h55
`define FSWC_KEY_SECOND 8'haa

// Write latch row
`define FSWC_ROW_WORDS 32
`define FSWC_ROW_BITS 5
`define FSWC_ROW_LAST 5'h1f

// Timing
`define FSWC_FORCED_NOPS 2'h2
`define FSWC_OP_TIME_US 2000
`define FSWC_CLK_MHZ 100
`define FSWC_OP_CYCLES (`FSWC_OP_TIME_US * `FSWC_CLK_MHZ)

// AHB-Lite
`define FSWC_HTRANS_NONSEQ 2'h2
`define FSWC_HSIZE_WORD 3'h2

`endif

// [fswc_flash_model.sv]
module fswc_flash_model (
  input wire clock_i,
  input wire [14:0] addr_i,
  input wire rd_i,
  input wire we_i,
  input wire [13:0] wdata_i,
  input wire erase_i,
  output wire [13:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] mem [0:63];
  initial begin
    for (int k = 0; k < 64; k++) begin
      mem[k] = 14'h1000 + 14'(k);
    end
  end
  // Outside a read strobe show the complement, never a stale word
  assign rdata_o = rd_i ? mem[addr_i[5:0]] : ~mem[addr_i[5:0]];
  always @(posedge clock_i) begin
    if (we_i) begin
      mem[addr_i[5:0]] <= wdata_i;
    end
    if (erase_i) begin
      for (int k = 0; k < 32; k++) begin
        mem[{addr_i[5], 5'(k)}] <= 14'h3fff;
      end
    end
  end
endmodule

// [fswc_op_timer.v]
`include "fswc_defines.vh"

module fswc_op_timer #(
  parameter integer CYCLES = `FSWC_OP_CYCLES
) (
  input wire clock_i,
  input wire srst_i,
  input wire start_i,
  output wire busy_o,
  output wire done_o
);

  localparam [31:0] LOAD = CYCLES - 1;

  reg [31:0] cnt_ff;
  reg busy_ff;
  reg done_ff;

  assign busy_o = busy_ff;
  assign done_o = done_ff;

  // Self-timed program/erase interval, done pulses one cycle at the end
  always @(posedge clock_i) begin
    if (srst_i) begin
      cnt_ff <= 32'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_i) begin
        cnt_ff <= LOAD;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == 32'h0) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 32'h1;
        end
      end
    end
  end

endmodule

// [fswc_top.v]
// Contract
// - Operations only right after uninterrupted unlock
// - Two forced no-operation cycles after start
// - Stall core during erase or program
// - Latch load: two no-ops, no stall
// - Data word 14 bits, high bits 7-6 zero
// - Address 15 bits, reset zero, bit7 one
// - Latch-only ignored on erase, else selects latch load over commit
// - Start bit self-clears, software cannot clear
`include "fswc_defines.vh"

module fswc_top #(
  parameter integer OP_CYCLES = `FSWC_OP_CYCLES
) (
  input wire clock_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire [13:0] flash_rdata_i,
  output wire [14:0] flash_addr_o,
  output wire flash_cfg_o,
  output wire flash_rd_o,
  output wire flash_we_o,
  output wire [13:0] flash_wdata_o,
  output wire flash_erase_o,
  output wire force_nop_o,
  output wire core_stall_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_NOP = 3'h1;
  localparam [2:0] ST_COPY = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;

  localparam [1:0] OP_LATCH = 2'h0;
  localparam [1:0] OP_COMMIT = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;

  localparam [1:0] KEY_NONE = 2'h0;
  localparam [1:0] KEY_FIRST = 2'h1;
  localparam [1:0] KEY_ARMED = 2'h2;

  function [2:0] reg_idx;
    input [7:0] ofs;
    begin
      case (ofs)
        `FSWC_OFS_DATA_LO: reg_idx = `FSWC_IDX_DATA_LO;
        `FSWC_OFS_DATA_HI: reg_idx = `FSWC_IDX_DATA_HI;
        `FSWC_OFS_ADDR_LO: reg_idx = `FSWC_IDX_ADDR_LO;
        `FSWC_OFS_ADDR_HI: reg_idx = `FSWC_IDX_ADDR_HI;
        `FSWC_OFS_CTRL: reg_idx = `FSWC_IDX_CTRL;
        `FSWC_OFS_KEY: reg_idx = `FSWC_IDX_KEY;
        default: reg_idx = `FSWC_IDX_NONE;
      endcase
    end
  endfunction

  // Bus slave state
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg [2:0] wr_idx_ff;
  reg [2:0] rd_idx_ff;
  reg [31:0] hrdata_ff;
  reg hreadyout_ff;
  reg hresp_ff;

  // Software visible registers
  reg [7:0] data_lo_ff;
  reg [5:0] data_hi_ff;
  reg [7:0] addr_lo_ff;
  reg [6:0] addr_hi_ff;
  reg config_space_select_ff;
  reg latch_only_load_ff;
  reg free_ff;
  reg sequence_error_flag_ff;
  reg program_erase_enable_ff;
  reg wr_ff;
  reg rd_ff;
  reg [1:0] key_ff;

  // Sequencer
  reg [2:0] state_ff;
  reg [1:0] op_ff;
  reg [1:0] nop_cnt_ff;
  reg [`FSWC_ROW_BITS-1:0] copy_idx_ff;
  reg tmr_start_ff;
  reg [14:0] flash_addr_ff;
  reg flash_cfg_ff;
  reg flash_rd_ff;
  reg flash_we_ff;
  reg [13:0] flash_wdata_ff;
  reg flash_erase_ff;
  reg force_nop_ff;
  reg core_stall_ff;

  reg [13:0] latch_mem [0:`FSWC_ROW_WORDS-1];
  reg [7:0] rd_mux;

  wire tmr_done;
  wire bus_take;
  wire ctrl_write;
  wire start_go;
  wire [7:0] wbyte;

  assign hrdata_o = hrdata_ff;
  assign hreadyout_o = hreadyout_ff;
  assign hresp_o = hresp_ff;
  assign flash_addr_o = flash_addr_ff;
  assign flash_cfg_o = flash_cfg_ff;
  assign flash_rd_o = flash_rd_ff;
  assign flash_we_o = flash_we_ff;
  assign flash_wdata_o = flash_wdata_ff;
  assign flash_erase_o = flash_erase_ff;
  assign force_nop_o = force_nop_ff;
  assign core_stall_o = core_stall_ff;

  assign bus_take = hsel_i & hready_i & (htrans_i == `FSWC_HTRANS_NONSEQ) & (hsize_i == `FSWC_HSIZE_WORD);
  assign wbyte = hwdata_i[7:0];
  // Control writes are ignored while an operation is in flight
  assign ctrl_write = wr_pend_ff & (wr_idx_ff == `FSWC_IDX_CTRL) & ~wr_ff & (state_ff == ST_IDLE);
  // Start only when armed by the key pair and enabled in the same control write
  assign start_go = ctrl_write & wbyte[`FSWC_CTRL_WR] & (key_ff == KEY_ARMED) &
                    wbyte[`FSWC_CTRL_PROGRAM_ERASE_ENABLE];

  fswc_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .start_i(tmr_start_ff),
    .busy_o(),
    .done_o(tmr_done)
  );

  always @* begin
    rd_mux = 8'h00;
    case (rd_idx_ff)
      `FSWC_IDX_DATA_LO: rd_mux = data_lo_ff;
      `FSWC_IDX_DATA_HI: rd_mux = {2'b00, data_hi_ff};
      `FSWC_IDX_ADDR_LO: rd_mux = addr_lo_ff;
      `FSWC_IDX_ADDR_HI: rd_mux = {1'b1, addr_hi_ff};
      `FSWC_IDX_CTRL: rd_mux = {1'b1, config_space_select_ff, latch_only_load_ff, free_ff,
                                sequence_error_flag_ff, program_erase_enable_ff, wr_ff, rd_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  // Data word and write latches hold no reset value
  always @(posedge clock_i) begin
    if (rd_ff) begin
      data_lo_ff <= flash_rdata_i[7:0];
      data_hi_ff <= flash_rdata_i[13:8];
    end else if (wr_pend_ff && wr_idx_ff == `FSWC_IDX_DATA_LO) begin
      data_lo_ff <= wbyte;
    end else if (wr_pend_ff && wr_idx_ff == `FSWC_IDX_DATA_HI) begin
      data_hi_ff <= wbyte[5:0];
    end
    // Erase leaves the latches alone whatever the latch-only bit says
    if (start_go && !wbyte[`FSWC_CTRL_FREE]) begin
      latch_mem[addr_lo_ff[`FSWC_ROW_BITS-1:0]] <= {data_hi_ff, data_lo_ff};
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_idx_ff <= `FSWC_IDX_NONE;
      rd_idx_ff <= `FSWC_IDX_NONE;
      hrdata_ff <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      addr_lo_ff <= `FSWC_ADDR_LO_RST;
      addr_hi_ff <= `FSWC_ADDR_HI_RST;
      config_space_select_ff <= 1'b0;
      latch_only_load_ff <= 1'b0;
      free_ff <= 1'b0;
      sequence_error_flag_ff <= 1'b0;
      program_erase_enable_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      key_ff <= KEY_NONE;
      state_ff <= ST_IDLE;
      op_ff <= OP_LATCH;
      nop_cnt_ff <= 2'h0;
      copy_idx_ff <= {`FSWC_ROW_BITS{1'b0}};
      tmr_start_ff <= 1'b0;
      flash_addr_ff <= 15'h0;
      flash_cfg_ff <= 1'b0;
      flash_rd_ff <= 1'b0;
      flash_we_ff <= 1'b0;
      flash_wdata_ff <= 14'h0;
      flash_erase_ff <= 1'b0;
      force_nop_ff <= 1'b0;
      core_stall_ff <= 1'b0;
    end else begin
      tmr_start_ff <= 1'b0;
      flash_we_ff <= 1'b0;
      flash_erase_ff <= 1'b0;
      flash_cfg_ff <= config_space_select_ff;

      // Address phase; reads take one wait state so data reflects earlier writes
      wr_pend_ff <= bus_take & hwrite_i;
      rd_pend_ff <= bus_take & ~hwrite_i;
      if (bus_take) begin
        if (hwrite_i) begin
          wr_idx_ff <= reg_idx(haddr_i[7:0]);
        end else begin
          rd_idx_ff <= reg_idx(haddr_i[7:0]);
          hreadyout_ff <= 1'b0;
        end
      end
      if (rd_pend_ff) begin
        hrdata_ff <= {24'h0, rd_mux};
        hreadyout_ff <= 1'b1;
      end

      // Any write other than the next expected key breaks the unlock
      if (wr_pend_ff) begin
        if (wr_idx_ff == `FSWC_IDX_KEY && wbyte == `FSWC_KEY_FIRST) begin
          key_ff <= KEY_FIRST;
        end else if (wr_idx_ff == `FSWC_IDX_KEY && wbyte == `FSWC_KEY_SECOND && key_ff == KEY_FIRST) begin
          key_ff <= KEY_ARMED;
        end else begin
          key_ff <= KEY_NONE;
        end
      end

      if (wr_pend_ff && wr_idx_ff == `FSWC_IDX_ADDR_LO) begin
        addr_lo_ff <= wbyte;
      end
      if (wr_pend_ff && wr_idx_ff == `FSWC_IDX_ADDR_HI) begin
        addr_hi_ff <= wbyte[6:0];
      end

      // One-cycle flash fetch; the data block captures while rd_ff is high
      if (rd_ff) begin
        rd_ff <= 1'b0;
        flash_rd_ff <= 1'b0;
      end

      if (ctrl_write) begin
        config_space_select_ff <= wbyte[`FSWC_CTRL_CONFIG_SPACE_SELECT];
        latch_only_load_ff <= wbyte[`FSWC_CTRL_LATCH_ONLY_LOAD];
        free_ff <= wbyte[`FSWC_CTRL_FREE];
        program_erase_enable_ff <= wbyte[`FSWC_CTRL_PROGRAM_ERASE_ENABLE];
        sequence_error_flag_ff <= wbyte[`FSWC_CTRL_SEQUENCE_ERROR_FLAG];
        if (wbyte[`FSWC_CTRL_RD] && !rd_ff) begin
          rd_ff <= 1'b1;
          flash_rd_ff <= 1'b1;
        end
        // Hardware set wins over the software value written alongside
        if (wbyte[`FSWC_CTRL_WR]) begin
          sequence_error_flag_ff <= 1'b1;
        end
      end

      if (start_go) begin
        wr_ff <= 1'b1;
        state_ff <= ST_NOP;
        nop_cnt_ff <= `FSWC_FORCED_NOPS - 2'h1;
        force_nop_ff <= 1'b1;
        if (wbyte[`FSWC_CTRL_FREE]) begin
          op_ff <= OP_ERASE;
        end else if (wbyte[`FSWC_CTRL_LATCH_ONLY_LOAD]) begin
          op_ff <= OP_LATCH;
        end else begin
          op_ff <= OP_COMMIT;
        end
      end

      case (state_ff)
        ST_IDLE: begin
          if (!start_go) begin
            flash_addr_ff <= {addr_hi_ff, addr_lo_ff};
          end
        end
        ST_NOP: begin
          if (nop_cnt_ff != 2'h0) begin
            nop_cnt_ff <= nop_cnt_ff - 2'h1;
          end else begin
            force_nop_ff <= 1'b0;
            case (op_ff)
              OP_LATCH: begin
                wr_ff <= 1'b0;
                sequence_error_flag_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
              OP_ERASE: begin
                flash_erase_ff <= 1'b1;
                core_stall_ff <= 1'b1;
                tmr_start_ff <= 1'b1;
                state_ff <= ST_WAIT;
              end
              OP_COMMIT: begin
                core_stall_ff <= 1'b1;
                copy_idx_ff <= {`FSWC_ROW_BITS{1'b0}};
                state_ff <= ST_COPY;
              end
              default: begin
                wr_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
            endcase
          end
        end
        ST_COPY: begin
          // Stream every latch of the row into the addressed flash row
          flash_we_ff <= 1'b1;
          flash_wdata_ff <= latch_mem[copy_idx_ff];
          flash_addr_ff <= {addr_hi_ff, addr_lo_ff[7:`FSWC_ROW_BITS], copy_idx_ff};
          copy_idx_ff <= copy_idx_ff + {{(`FSWC_ROW_BITS-1){1'b0}}, 1'b1};
          if (copy_idx_ff == `FSWC_ROW_LAST) begin
            tmr_start_ff <= 1'b1;
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            core_stall_ff <= 1'b0;
            wr_ff <= 1'b0;
            free_ff <= 1'b0;
            sequence_error_flag_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [fswc_top_bench.sv]
module fswc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, flash_cfg_o, flash_rd_o, flash_we_o, flash_erase_o, force_nop_o, core_stall_o;
  wire [13:0] flash_rdata_i, flash_wdata_o;
  wire [14:0] flash_addr_o;
  int err_count = 0;
  int check_count = 0;
  int nop_n = 0, we_n = 0, er_n = 0, st_n = 0, n0, w0, e0, s0;
  logic [31:0] q;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    nop_n += force_nop_o;
    we_n += flash_we_o;
    er_n += flash_erase_o;
    st_n += core_stall_o;
  end
  fswc_top #(.OP_CYCLES(20)) dut (.clock_i(clock_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(), .flash_rdata_i(flash_rdata_i),
    .flash_addr_o(flash_addr_o), .flash_cfg_o(flash_cfg_o), .flash_rd_o(flash_rd_o), .flash_we_o(flash_we_o),
    .flash_wdata_o(flash_wdata_o), .flash_erase_o(flash_erase_o), .force_nop_o(force_nop_o),
    .core_stall_o(core_stall_o));
  fswc_flash_model u_flash (.clock_i(clock_i), .addr_i(flash_addr_o), .rd_i(flash_rd_o), .we_i(flash_we_o),
    .wdata_i(flash_wdata_o), .erase_i(flash_erase_o), .rdata_o(flash_rdata_i));
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h0, e}, q);
  endtask
  task automatic go(input logic [7:0] c);
    n0 = nop_n; w0 = we_n; e0 = er_n; s0 = st_n;
    wr(8'h14, 8'h55);
    wr(8'h14, 8'haa);
    wr(8'h10, c);
    repeat (4) @(posedge clock_i);
    while (core_stall_o === 1'b1) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
  endtask
  task automatic t_regs;
    rd(8'h08, 8'h00, "adr_lo");
    rd(8'h0c, 8'h80, "adr_hi");
    rd(8'h10, 8'h80, "ctrl");
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h3f, "dat_hi");
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'hff, "adr_hi_w");
    wr(8'h18, 8'h12);
    rd(8'h18, 8'h00, "unmapped");
    wr(8'h10, 8'h40);
    repeat (2) @(posedge clock_i);
    chk("cfg", 32'h1, flash_cfg_o);
    wr(8'h10, 8'h00);
    wr(8'h0c, 8'h00);
  endtask
  task automatic t_fetch(input logic [7:0] a, input logic [13:0] e);
    wr(8'h08, a);
    wr(8'h10, 8'h01);
    repeat (3) @(posedge clock_i);
    rd(8'h00, e[7:0], "fetch_lo");
    rd(8'h04, {2'h0, e[13:8]}, "fetch_hi");
    rd(8'h10, 8'h80, "rd_clr");
  endtask
  task automatic t_latch;
    wr(8'h08, 8'h23);
    wr(8'h00, 8'h5a);
    wr(8'h04, 8'h2c);
    go(8'h26);
    chk("nops", 32'h2, nop_n - n0);
    chk("stall", 32'h0, st_n - s0);
    rd(8'h10, 8'ha4, "ctrl_ll");
  endtask
  task automatic t_bad;
    n0 = nop_n;
    wr(8'h14, 8'h55);
    wr(8'h00, 8'h5a);
    wr(8'h14, 8'haa);
    wr(8'h10, 8'h06);
    repeat (4) @(posedge clock_i);
    chk("nops_brk", 32'h0, nop_n - n0);
    rd(8'h10, 8'h8c, "err_brk");
    go(8'h02);
    chk("nops_dis", 32'h0, nop_n - n0);
    rd(8'h10, 8'h88, "err_dis");
  endtask
  task automatic t_commit;
    go(8'h06);
    chk("burst", 32'h20, we_n - w0);
    chk("nops_c", 32'h2, nop_n - n0);
    chk("stalled", 32'h1, st_n - s0 >= 32);
    rd(8'h10, 8'h84, "ctrl_done");
    t_fetch(8'h23, 14'h2c5a);
  endtask
  task automatic t_erase;
    go(8'h36);
    chk("erase", 32'h1, er_n - e0);
    chk("no_we", 32'h0, we_n - w0);
    rd(8'h10, 8'ha4, "ctrl_er");
    t_fetch(8'h23, 14'h3fff);
  endtask
  // A clearing write during an erase must leave the start bit set
  task automatic t_noclr;
    e0 = er_n;
    wr(8'h14, 8'h55);
    wr(8'h14, 8'haa);
    wr(8'h10, 8'h16);
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h9e, "wr_kept");
    while (core_stall_o === 1'b1) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    chk("erase_2", 32'h1, er_n - e0);
    rd(8'h10, 8'h84, "wr_done");
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    t_regs;
    t_fetch(8'h05, 14'h1005);
    t_latch;
    t_bad;
    t_commit;
    t_erase;
    t_noclr;
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    complete_run;
  end
endmodule

// [fswc_top_sva.sv]
module fswc_top_sva #(
  parameter integer OP_CYCLES = 20
) (
  input wire clock_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hrdata_o,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire flash_rd_o,
  input wire flash_we_o,
  input wire flash_erase_o,
  input wire force_nop_o,
  input wire core_stall_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] we_run;
  logic [31:0] st_run;
  wire take = hsel_i && hready_i && htrans_i == 2'h2 && hsize_i == 3'h2;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  always @(posedge clock_i) begin
    we_run <= flash_we_o ? we_run + 8'h01 : 8'h00;
    st_run <= core_stall_o ? st_run + 32'h1 : 32'h0;
  end
  sequence s_rd_take;
    take && !hwrite_i;
  endsequence
  sequence s_one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_read_wait: assert property (s_rd_take |=> s_one_wait) else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite_i |=> hreadyout_o) else $error("write stalled");
  a_addr_hi_one: assert property (s_rd_take ##0 haddr_i[7:0] == 8'h0c |-> ##2 hrdata_o[7]) else $error("bit7");
  a_data_hi_zero: assert property (s_rd_take ##0 haddr_i[7:0] == 8'h04 |-> ##2 hrdata_o[7:6] == 2'h0) else $error("hi");
  a_nop_two: assert property ($rose(force_nop_o) |=> force_nop_o ##1 !force_nop_o) else $error("nop len");
  a_rd_pulse: assert property (flash_rd_o |=> !flash_rd_o) else $error("rd pulse");
  a_erase_pulse: assert property (flash_erase_o |=> !flash_erase_o && core_stall_o) else $error("erase");
  a_we_burst: assert property ($fell(flash_we_o) |-> we_run == 8'h20) else $error("burst len");
  a_we_stalled: assert property (flash_we_o |-> core_stall_o) else $error("we unstalled");
  a_stall_bound: assert property (core_stall_o |-> st_run < OP_CYCLES + 64) else $error("stall long");
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("resp");
endmodule

bind fswc_top fswc_top_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hsize_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .flash_rd_o, .flash_we_o,
  .flash_erase_o, .force_nop_o, .core_stall_o);
